// >>> msd_pkg.sv
`default_nettype none
package msd_pkg;

  // ----------------------------------------------------------------
  // Register offsets within the module register block
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PAGE_OFS = 8'he0;
  localparam logic [7:0] REG_MAP_OFS  = 8'hc2;
  localparam logic [7:0] REG_PC0_OFS  = 8'hb0;
  localparam logic [7:0] REG_PC2_OFS  = 8'hb4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAP_SRAM_CODE = 0;
  localparam int MAP_SEC_CODE  = 1;
  localparam int MAP_PRI_CODE  = 2;
  localparam int MAP_SEC_DATA  = 3;
  localparam int MAP_PRI_DATA  = 4;
  localparam int MAP_PERIPHERAL_IO_ENABLE    = 7;
  localparam int PC0_TURBO     = 3;
  localparam int PC0_STANDBY   = 7;
  localparam int PC2_BLK_FETCH = 0;
  localparam int PC2_BLK_READ  = 1;
  localparam int PC2_BLK_WRITE = 2;
  localparam int PC2_BLK_LATCH = 3;
  localparam int PC2_BLK_PDN   = 4;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] MAP_INIT    = 8'h0c;
  localparam logic [7:0] PAGE_RESET  = 8'h00;
  localparam logic [7:0] PC0_RESET   = 8'h08;
  localparam logic [7:0] PC2_RESET   = 8'h00;
  localparam logic [7:0] PC2_WR_MASK = 8'h1f;
  localparam logic [7:0] PC0_WR_MASK = 8'h08;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int IDLE_TIME_NS  = 70;
  localparam int IDLE_CYCLES   = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Decode array shape
  // ----------------------------------------------------------------
  localparam int NUM_PRI      = 4;
  localparam int NUM_SEC      = 2;
  localparam int NUM_PERIPH   = 2;
  localparam int FLASH_TERMS  = 3;
  localparam int SRAM_TERMS   = 2;
  localparam int IN_WORD_W    = 32;

  typedef struct packed {
    logic                 en;
    logic [15:0]          addr_mask;
    logic [15:0]          addr_val;
    logic [IN_WORD_W-1:0] in_mask;
    logic [IN_WORD_W-1:0] in_val;
  } msd_pterm_t;

  typedef struct packed {
    logic                  sram;
    logic [NUM_PRI-1:0]    pri;
    logic [NUM_SEC-1:0]    sec;
    logic                  regs;
    logic [NUM_PERIPH-1:0] periph;
  } msd_selects_t;

  localparam msd_pterm_t PT_OFF = '0;

  function automatic msd_pterm_t pt(input logic [15:0] mask, input logic [15:0] val);
    msd_pterm_t t;
    t           = '0;
    t.en        = 1'b1;
    t.addr_mask = mask;
    t.addr_val  = val;
    return t;
  endfunction

  // Default configuration: index is select*terms + term
  localparam msd_pterm_t [NUM_PRI*FLASH_TERMS-1:0] PRI_CFG_DEFAULT = {
    PT_OFF, PT_OFF, pt(16'hc000, 16'hc000),
    PT_OFF, PT_OFF, pt(16'hc000, 16'h8000),
    PT_OFF, PT_OFF, pt(16'hc000, 16'h4000),
    PT_OFF, PT_OFF, pt(16'hc000, 16'h0000)};
  localparam msd_pterm_t [NUM_SEC*FLASH_TERMS-1:0] SEC_CFG_DEFAULT = {
    PT_OFF, PT_OFF, pt(16'he000, 16'h2000),
    PT_OFF, PT_OFF, pt(16'he000, 16'h0000)};
  localparam msd_pterm_t [SRAM_TERMS-1:0] SRAM_CFG_DEFAULT = {
    PT_OFF, pt(16'hf800, 16'h4000)};
  localparam msd_pterm_t REG_CFG_DEFAULT = pt(16'hff00, 16'h7f00);
  localparam msd_pterm_t [NUM_PERIPH-1:0] PERIPH_CFG_DEFAULT = {
    pt(16'hff00, 16'h7e00), pt(16'hff00, 16'h7d00)};

endpackage
`default_nettype wire

// >>> msd_select_or.sv
`timescale 1ns/1ns
`default_nettype none
module msd_select_or #(
  parameter int N = 1
) (
  input  wire logic [15:0]                      addr,
  input  wire logic [msd_pkg::IN_WORD_W-1:0]    in_word,
  input  wire msd_pkg::msd_pterm_t [N-1:0]      terms,
  output logic                                  hit
);

  function automatic logic term_match(input msd_pkg::msd_pterm_t t,
                                      input logic [15:0] a,
                                      input logic [msd_pkg::IN_WORD_W-1:0] w);
    term_match = t.en && ((a & t.addr_mask) == (t.addr_val & t.addr_mask))
                      && ((w & t.in_mask) == (t.in_val & t.in_mask));
  endfunction

  // ----------------------------------------------------------------
  // OR of product terms
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < N; i++) begin
      hit = hit | term_match(terms[i], addr, in_word);
    end
  end

endmodule
`default_nettype wire

// >>> msd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - SRAM is enabled only while its select output is high.
// - SRAM select is the OR of up to two product terms.
// - Secondary flash wins over primary flash on overlap.
// - SRAM, register or peripheral space wins over any flash sector.
// - Three priority levels; higher level overrides lower ones.
// - Each flash memory may sit in program space, data space or both; SRAM is always in data space, optionally also program.
// - Map register starts at configured value, writable any time the write strobe is not blocked by PC2 bit 2.
// - Fetch access: bit 2 primary, bit 1 secondary, bit 0 SRAM.
// - Eight-bit page register, read and write, feeds decode terms.
// - Page register answers at offset e0h in the register block.
// - Page bits also go out to the general logic array.
// - Decode inputs: address, strobes, reset, power-down, ports, page, feedback, ready.
// - Decode configuration is active from power-up, no loading step.
// - With turbo bit clear, arrays idle after about 70 ns of steady inputs.
// - Five bits block one MCU control signal each from the arrays.
// - Flash sector selects are active high.
module msd_decoder #(
  parameter logic [7:0] MAP_INIT = msd_pkg::MAP_INIT,
  parameter msd_pkg::msd_pterm_t [msd_pkg::NUM_PRI*msd_pkg::FLASH_TERMS-1:0] PRI_CFG =
    msd_pkg::PRI_CFG_DEFAULT,
  parameter msd_pkg::msd_pterm_t [msd_pkg::NUM_SEC*msd_pkg::FLASH_TERMS-1:0] SEC_CFG =
    msd_pkg::SEC_CFG_DEFAULT,
  parameter msd_pkg::msd_pterm_t [msd_pkg::SRAM_TERMS-1:0] SRAM_CFG =
    msd_pkg::SRAM_CFG_DEFAULT,
  parameter msd_pkg::msd_pterm_t REG_CFG = msd_pkg::REG_CFG_DEFAULT,
  parameter msd_pkg::msd_pterm_t [msd_pkg::NUM_PERIPH-1:0] PERIPH_CFG =
    msd_pkg::PERIPH_CFG_DEFAULT
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic [15:0]          addr,
  input  wire logic                 program_fetch_strobe_n,
  input  wire logic                 read_strobe_n,
  input  wire logic                 write_strobe_n,
  input  wire logic                 addr_latch,
  input  wire logic                 power_down,
  input  wire logic                 flash_ready_busy,
  input  wire logic [7:0]           macrocell_feedback,
  input  wire logic [7:0]           port_in,
  input  wire logic [7:0]           data_in,
  output logic [7:0]                data_out,
  output logic                      data_oe,
  output msd_pkg::msd_selects_t     selects,
  output logic                      sram_enable,
  output logic [7:0]                page_bits,
  output logic                      array_standby
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]            page_reg;
  logic [7:0]            map_reg;
  logic [7:0]            pc0_reg;
  logic [7:0]            pc2_reg;
  logic [7:0]            port_meta_reg;
  logic [7:0]            port_sync_reg;
  logic                  reset_flag_reg;
  logic                  wr_prev_reg;
  logic [7:0]            data_out_reg;
  logic                  data_oe_reg;
  msd_pkg::msd_selects_t selects_reg;
  msd_pkg::msd_selects_t selects_next;
  logic [7:0]            page_bits_reg;
  logic                  standby_reg;
  logic [2:0]            idle_cnt_reg;
  logic [15:0]           addr_prev_reg;
  logic [31:0]           word_prev_reg;

  // ----------------------------------------------------------------
  // Control signals into the arrays
  // ----------------------------------------------------------------
  logic fetch_act;
  logic rd_act;
  logic wr_act;
  logic ale_act;
  logic pdn_act;
  logic data_act;
  logic [msd_pkg::IN_WORD_W-1:0] in_word;

  assign fetch_act = ~program_fetch_strobe_n & ~pc2_reg[msd_pkg::PC2_BLK_FETCH];
  assign rd_act    = ~read_strobe_n & ~pc2_reg[msd_pkg::PC2_BLK_READ];
  assign wr_act    = ~write_strobe_n & ~pc2_reg[msd_pkg::PC2_BLK_WRITE];
  assign ale_act   = addr_latch & ~pc2_reg[msd_pkg::PC2_BLK_LATCH];
  assign pdn_act   = power_down & ~pc2_reg[msd_pkg::PC2_BLK_PDN];
  assign data_act  = rd_act | wr_act;

  // Decode input word beyond the address lines
  assign in_word = {page_reg, macrocell_feedback, port_sync_reg, ale_act, rd_act, wr_act,
                    fetch_act, pdn_act, flash_ready_busy, reset_flag_reg, 1'b0};

  // ----------------------------------------------------------------
  // Port input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_meta_reg <= 8'h00;
      port_sync_reg <= 8'h00;
    end else begin
      port_meta_reg <= port_in;
      port_sync_reg <= port_meta_reg;
    end
  end

  // Reset term stays high for one cycle after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_flag_reg <= 1'b1;
    end else begin
      reset_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Decode array product terms
  // ----------------------------------------------------------------
  logic [msd_pkg::NUM_PRI-1:0]    pri_hit;
  logic [msd_pkg::NUM_SEC-1:0]    sec_hit;
  logic [msd_pkg::NUM_PERIPH-1:0] periph_hit;
  logic                           sram_hit;
  logic                           reg_hit;

  for (genvar s = 0; s < msd_pkg::NUM_PRI; s++) begin : g_pri
    msd_select_or #(.N(msd_pkg::FLASH_TERMS)) u_or (.addr(addr), .in_word(in_word),
      .terms(PRI_CFG[s*msd_pkg::FLASH_TERMS +: msd_pkg::FLASH_TERMS]), .hit(pri_hit[s]));
  end

  for (genvar s = 0; s < msd_pkg::NUM_SEC; s++) begin : g_sec
    msd_select_or #(.N(msd_pkg::FLASH_TERMS)) u_or (.addr(addr), .in_word(in_word),
      .terms(SEC_CFG[s*msd_pkg::FLASH_TERMS +: msd_pkg::FLASH_TERMS]), .hit(sec_hit[s]));
  end

  for (genvar s = 0; s < msd_pkg::NUM_PERIPH; s++) begin : g_periph
    msd_select_or #(.N(1)) u_or (.addr(addr), .in_word(in_word),
      .terms(PERIPH_CFG[s]), .hit(periph_hit[s]));
  end

  msd_select_or #(.N(msd_pkg::SRAM_TERMS)) u_sram_or (.addr(addr), .in_word(in_word),
    .terms(SRAM_CFG), .hit(sram_hit));

  msd_select_or #(.N(1)) u_reg_or (.addr(addr), .in_word(in_word),
    .terms(REG_CFG), .hit(reg_hit));

  // ----------------------------------------------------------------
  // Space gating and priority
  // ----------------------------------------------------------------
  logic [msd_pkg::NUM_PRI-1:0]    pri_ok;
  logic [msd_pkg::NUM_SEC-1:0]    sec_ok;
  logic [msd_pkg::NUM_PERIPH-1:0] periph_ok;
  logic                           sram_ok;
  logic                           reg_ok;
  logic                           level_one;

  assign pri_ok = pri_hit & {msd_pkg::NUM_PRI{
                    (fetch_act & map_reg[msd_pkg::MAP_PRI_CODE])
                  | (data_act & map_reg[msd_pkg::MAP_PRI_DATA])}};
  assign sec_ok = sec_hit & {msd_pkg::NUM_SEC{
                    (fetch_act & map_reg[msd_pkg::MAP_SEC_CODE])
                  | (data_act & map_reg[msd_pkg::MAP_SEC_DATA])}};
  assign sram_ok   = sram_hit & ((fetch_act & map_reg[msd_pkg::MAP_SRAM_CODE]) | data_act);
  assign reg_ok    = reg_hit & data_act;
  assign periph_ok = periph_hit & {msd_pkg::NUM_PERIPH{data_act & map_reg[msd_pkg::MAP_PERIPHERAL_IO_ENABLE]}};
  assign level_one = sram_ok | reg_ok | (|periph_ok);

  always_comb begin
    selects_next        = '0;
    selects_next.sram   = sram_ok;
    selects_next.regs   = reg_ok;
    selects_next.periph = periph_ok;
    if (!level_one) begin
      selects_next.sec = sec_ok;
      if (sec_ok == '0) begin
        selects_next.pri = pri_ok;
      end
    end
  end

  // Active-high selects, refreshed every cycle from the live inputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selects_reg <= '0;
    end else begin
      selects_reg <= selects_next;
    end
  end

  // ----------------------------------------------------------------
  // Register block access
  // ----------------------------------------------------------------
  logic       reg_write;
  logic [7:0] reg_ofs;
  logic [7:0] reg_rdata;

  assign reg_ofs   = addr[7:0];
  assign reg_write = reg_hit & wr_act & wr_prev_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_prev_reg <= 1'b1;
    end else begin
      wr_prev_reg <= ~wr_act;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_reg <= msd_pkg::PAGE_RESET;
    end else if (reg_write && reg_ofs == msd_pkg::REG_PAGE_OFS) begin
      page_reg <= data_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      map_reg <= MAP_INIT;
    end else if (reg_write && reg_ofs == msd_pkg::REG_MAP_OFS) begin
      map_reg <= data_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc0_reg <= msd_pkg::PC0_RESET;
    end else if (reg_write && reg_ofs == msd_pkg::REG_PC0_OFS) begin
      pc0_reg <= data_in & msd_pkg::PC0_WR_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc2_reg <= msd_pkg::PC2_RESET;
    end else if (reg_write && reg_ofs == msd_pkg::REG_PC2_OFS) begin
      pc2_reg <= data_in & msd_pkg::PC2_WR_MASK;
    end
  end

  always_comb begin
    case (reg_ofs)
      msd_pkg::REG_PAGE_OFS: reg_rdata = page_reg;
      msd_pkg::REG_MAP_OFS:  reg_rdata = map_reg;
      msd_pkg::REG_PC0_OFS:  reg_rdata = {standby_reg, pc0_reg[6:0]};
      msd_pkg::REG_PC2_OFS:  reg_rdata = pc2_reg;
      default:               reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out_reg <= 8'h00;
      data_oe_reg  <= 1'b0;
    end else begin
      data_out_reg <= reg_rdata;
      data_oe_reg  <= reg_hit & rd_act;
    end
  end

  // ----------------------------------------------------------------
  // Page bits to the general logic array
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_bits_reg <= msd_pkg::PAGE_RESET;
    end else begin
      page_bits_reg <= page_reg;
    end
  end

  // ----------------------------------------------------------------
  // Standby when not in turbo mode
  // ----------------------------------------------------------------
  logic inputs_changed;
  logic turbo;

  assign turbo          = pc0_reg[msd_pkg::PC0_TURBO];
  assign inputs_changed = (addr != addr_prev_reg) || (in_word != word_prev_reg);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_prev_reg <= 16'h0000;
      word_prev_reg <= 32'h0000_0000;
    end else begin
      addr_prev_reg <= addr;
      word_prev_reg <= in_word;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_reg <= 3'h0;
    end else if (inputs_changed || turbo) begin
      idle_cnt_reg <= 3'h0;
    end else if (idle_cnt_reg != 3'(msd_pkg::IDLE_CYCLES)) begin
      idle_cnt_reg <= idle_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      standby_reg <= 1'b0;
    end else begin
      standby_reg <= ~turbo & ~inputs_changed
                   & (idle_cnt_reg >= 3'(msd_pkg::IDLE_CYCLES - 1));
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign selects       = selects_reg;
  assign sram_enable   = selects_reg.sram;
  assign page_bits     = page_bits_reg;
  assign array_standby = standby_reg;
  assign data_out      = data_out_reg;
  assign data_oe       = data_oe_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sram_fetch_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (fetch_act && !data_act && !map_reg[msd_pkg::MAP_SRAM_CODE]) |=> !sram_enable)
    else $error("SRAM selected on fetch while fetch access is off");
  a_pri_fetch_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (fetch_act && !data_act && !map_reg[msd_pkg::MAP_PRI_CODE]) |=> (selects.pri == '0))
    else $error("Primary flash selected on fetch while fetch access is off");
  a_pri_data_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_act && !fetch_act && !wr_act && !map_reg[msd_pkg::MAP_PRI_DATA])
      |=> (selects.pri == '0))
    else $error("Primary flash selected on read while data access is off");
  a_sec_over_pri: assert property (@(posedge clk) disable iff (!reset_n)
    (sec_ok != '0 && !level_one) |=> (selects.sec != '0 && selects.pri == '0))
    else $error("Secondary flash did not win over primary flash");
  a_lvl1_over_flash: assert property (@(posedge clk) disable iff (!reset_n)
    level_one |=> (selects.pri == '0 && selects.sec == '0))
    else $error("Flash select active together with level one select");
  a_sram_follows_hit: assert property (@(posedge clk) disable iff (!reset_n)
    (sram_hit && data_act) |=> sram_enable)
    else $error("SRAM not enabled on a matching data access");
  a_page_write: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_write && reg_ofs == msd_pkg::REG_PAGE_OFS) |=> ##1 (page_bits == $past(data_in, 2)))
    else $error("Page write did not reach the page bits");
  a_map_write: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_write && reg_ofs == msd_pkg::REG_MAP_OFS) |=> (map_reg == $past(data_in)))
    else $error("Map register write lost");
  a_standby_enter: assert property (@(posedge clk) disable iff (!reset_n)
    (!inputs_changed && !turbo)[*4] |=> array_standby)
    else $error("Arrays not in standby after steady inputs");
  a_standby_leave: assert property (@(posedge clk) disable iff (!reset_n)
    (inputs_changed || turbo) |=> !array_standby)
    else $error("Standby held after input change or in turbo mode");

endmodule
`default_nettype wire

// >>> msd_mcu_bfm.sv
`timescale 1ns/1ns
`default_nettype none
module msd_mcu_bfm (
  input  wire logic [7:0] data_out,
  input  wire logic       clk,
  output logic [15:0]     addr,
  output logic            fetch_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [7:0]      data_in
);
  // ------------------------------
  // Core bus cycles
  // ------------------------------
  initial begin
    addr = 16'h0000;
    fetch_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 8'h00;
  end

  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
    @(posedge clk);
    addr <= {8'h7f, ofs};
    data_in <= d;
    wr_n <= 1'b0;
    @(posedge clk);
    wr_n <= 1'b1;
    data_in <= ~d;  // Released data no longer valid
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [7:0] ofs, output logic [7:0] d);
    @(posedge clk);
    addr <= {8'h7f, ofs};
    rd_n <= 1'b0;
    @(posedge clk);
    rd_n <= 1'b1;
    #1;
    d = data_out;
  endtask

  task automatic access(input logic [15:0] a, input bit f);
    @(posedge clk);
    addr <= a;
    fetch_n <= !f;
    rd_n <= f;
    @(posedge clk);
    fetch_n <= 1'b1;
    rd_n <= 1'b1;
    #1;
  endtask
endmodule
`default_nettype wire

// >>> tb_memory_select_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module tb_memory_select_decoder;
  logic                  clk, reset_n, latch, pdn, rdy, fetch_n, rd_n, wr_n, oe, sram_en, stby;
  logic [7:0]            fb, pin, din, dout, rv, map, pgv, pg;
  logic [15:0]           addr;
  msd_pkg::msd_selects_t sel, es;
  int                    mismatches, n_checks;
  logic [15:0]           alist [10] = '{16'h0000, 16'h2000, 16'h4000, 16'h4100, 16'h4800,
                                        16'h8000, 16'hc000, 16'h7d10, 16'h7e10, 16'h7f10};

  msd_mcu_bfm mcu (.clk(clk), .data_out(dout), .addr(addr), .fetch_n(fetch_n),
    .rd_n(rd_n), .wr_n(wr_n), .data_in(din));
  msd_decoder dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
    .program_fetch_strobe_n(fetch_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .addr_latch(latch), .power_down(pdn), .flash_ready_busy(rdy), .macrocell_feedback(fb),
    .port_in(pin), .data_in(din), .data_out(dout), .data_oe(oe), .selects(sel),
    .sram_enable(sram_en), .page_bits(pg), .array_standby(stby));

  // ------------------------------
  // Reference decode and checking
  // ------------------------------
  function automatic msd_pkg::msd_selects_t exp_sel(logic [15:0] a, bit f, logic [7:0] m);
    msd_pkg::msd_selects_t s;
    s = '0;
    if (a[15:11] == 5'b01000 && (!f || m[0])) s.sram = 1'b1;
    else if (!f && a[15:8] == 8'h7f) s.regs = 1'b1;
    else if (!f && m[7] && (a[15:8] == 8'h7d || a[15:8] == 8'h7e)) s.periph[a[9]] = 1'b1;
    else if (a[15:14] == 2'b00 && (f ? m[1] : m[3])) s.sec[a[13]] = 1'b1;
    else if (f ? m[2] : m[4]) s.pri[a[15:14]] = 1'b1;
    return s;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end

  // ------------------------------
  // Test sequence
  // ------------------------------
  initial begin
    void'($urandom(32'h57b5));
    {reset_n, latch, pdn, rdy, fb, pin} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    mcu.access(16'h4000, 1'b0);
    chk(sel, exp_sel(16'h4000, 1'b0, msd_pkg::MAP_INIT));
    mcu.reg_rd(msd_pkg::REG_MAP_OFS, rv);
    chk(rv, msd_pkg::MAP_INIT);
    mcu.reg_rd(msd_pkg::REG_PAGE_OFS, rv);
    chk(rv, 8'h00);
    chk(oe, 1'b1);
    mcu.reg_rd(8'h55, rv);
    chk(rv, 8'h00);
    for (int i = 0; i < 8; i++) begin
      map = (i == 0) ? 8'h0c : (i == 1) ? 8'h14 : 8'($urandom);
      pgv = 8'($urandom);
      mcu.reg_wr(msd_pkg::REG_PAGE_OFS, pgv);
      mcu.reg_rd(msd_pkg::REG_PAGE_OFS, rv);
      chk(rv, pgv);
      chk(pg, pgv);
      mcu.reg_wr(msd_pkg::REG_MAP_OFS, map);
      mcu.reg_rd(msd_pkg::REG_MAP_OFS, rv);
      chk(rv, map);
      foreach (alist[j]) begin
        for (int f = 0; f < 2; f++) begin
          @(posedge clk);
          {latch, pdn, rdy, fb, pin} <= 19'($urandom);
          mcu.access(alist[j], f[0]);
          es = exp_sel(alist[j], f[0], map);
          chk(sel, es);
          chk(sram_en, es.sram);
        end
      end
    end
    mcu.reg_wr(msd_pkg::REG_PC2_OFS, 8'h03);
    mcu.reg_rd(msd_pkg::REG_PAGE_OFS, rv);
    chk(oe, 1'b0);
    mcu.access(16'h0000, 1'b1);
    chk(sel, 16'h0000);
    mcu.reg_wr(msd_pkg::REG_PC2_OFS, 8'h00);
    repeat (8) @(posedge clk);
    #1;
    chk(stby, 1'b0);
    mcu.reg_wr(msd_pkg::REG_PC0_OFS, 8'h00);
    repeat (8) @(posedge clk);
    #1;
    chk(stby, 1'b1);
    mcu.access(16'h8000, 1'b0);
    chk(stby, 1'b0);
    mcu.reg_wr(msd_pkg::REG_PC0_OFS, 8'h08);
    report_and_stop();
  end
endmodule
`default_nettype wire
